// >>> irq_status0_flags.sv
// Eight sticky event flags shared by the clearing and peeking views.
// Assumes event pulses synchronous to ref_clk_i.
module irq_status0_flags (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire irq_status0_pkg::irq_events_t events_i,
    input wire logic clear_all_i,
    output logic [7:0] flags_o
);
    logic [7:0] next_flags;

    // Set wins over clear so an event in the clear cycle survives
    assign next_flags = (clear_all_i ? irq_status0_pkg::STATUS0_RESET : flags_o) | events_i;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            flags_o <= irq_status0_pkg::STATUS0_RESET;
        else
            flags_o <= next_flags;
    end
endmodule

// >>> irq_status0_monitor.sv
// Checker: APB answers and flag relations of the peek view.
// Assumes bind onto the top module.
module irq_status0_monitor (
    input wire logic ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i,
    input wire logic packet_end_read_i, rx_queue_empty_i, self_setup_done_i,
    input wire logic osc_ready_i, nvm_op_done_i, tx_done_i, rx_queue_full_i,
    input wire logic packet_arrived_i, pready_o, pslverr_o,
    input wire logic [irq_status0_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic [7:0] irq_status0_peek_o
);
    wire logic [7:0] pk = irq_status0_peek_o;
    wire logic [7:0] ev = {packet_end_read_i, rx_queue_empty_i, self_setup_done_i,
        osc_ready_i, nvm_op_done_i, tx_done_i, rx_queue_full_i, packet_arrived_i};
    wire logic s = psel_i && !penable_i;
    wire logic pa = paddr_i == irq_status0_pkg::ADDR_STATUS0_PEEK;
    wire logic ca = paddr_i == irq_status0_pkg::ADDR_STATUS0_CLEAR;
    wire logic rc = s && !pwrite_i && ca;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    property p_ans; s |=> pready_o; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; pready_o |=> !pready_o; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_err; s && !pa && !ca |=> pslverr_o && prdata_o == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped ok");
    property p_wr; s && pwrite_i && (pa || ca) |=> !pslverr_o; endproperty
    a_wr: assert property (p_wr) else $error("write error");
    property p_hi; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits");
    property p_same; pready_o && !pwrite_i && !pslverr_o |-> prdata_o[7:0] == pk; endproperty
    a_same: assert property (p_same) else $error("views differ");
    property p_set; ev != 8'h0 |-> ##2 (pk & $past(ev, 2)) == $past(ev, 2); endproperty
    a_set: assert property (p_set) else $error("flag unset");
    property p_keep; ($past(pk) & ~pk) != 8'h0 |-> $past(rc, 2); endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_clr; rc && ev == 8'h0 |-> ##2 pk == 8'h0; endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    c_rc: cover property (rc);
    c_pk: cover property (s && pa && !pwrite_i);
    c_err: cover property (pslverr_o);
endmodule
bind irq_status0_peek_view irq_status0_monitor m (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .packet_end_read_i(packet_end_read_i),
    .rx_queue_empty_i(rx_queue_empty_i),
    .self_setup_done_i(self_setup_done_i),
    .osc_ready_i(osc_ready_i),
    .nvm_op_done_i(nvm_op_done_i),
    .tx_done_i(tx_done_i),
    .rx_queue_full_i(rx_queue_full_i),
    .packet_arrived_i(packet_arrived_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .paddr_i(paddr_i),
    .prdata_o(prdata_o),
    .irq_status0_peek_o(irq_status0_peek_o)
);

// >>> irq_status0_peek_view.sv
// APB view of the first interrupt status group: peek and clear-on-read.
// Assumes an APB master on ref_clk_i and event pulses from the device core.
// Reset is synchronous and active low; every pin shares ref_clk_i.
// Write data is carried but unused: no bit of either view is writable.
// What this block does
// - Read-only peek register, writes ignored
// - Bit 7: packet last byte read
// - Bit 6: receive queue became empty
// - Bit 5: self initialization finished
// - Bit 4: oscillator start-up finished
// - Bit 3: non-volatile program/erase finished
// - Bit 2: packet transmission finished
// - Bit 1: receive queue became full
// - Bit 0: packet appended to receive buffer
// - Only companion register read clears all
module irq_status0_peek_view (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [irq_status0_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic packet_end_read_i,
    input wire logic rx_queue_empty_i,
    input wire logic self_setup_done_i,
    input wire logic osc_ready_i,
    input wire logic nvm_op_done_i,
    input wire logic tx_done_i,
    input wire logic rx_queue_full_i,
    input wire logic packet_arrived_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    output logic [7:0] irq_status0_peek_o
);
    ////////////////////////////////////////////////////////////////////
    // Bus side
    irq_status0_pkg::apb_req_t req;
    logic setup;
    logic read_setup;
    logic hit_peek;
    logic hit_clear;
    logic mapped;
    logic clear_read;

    // Event and flag side
    irq_status0_pkg::irq_events_t events;
    irq_status0_pkg::irq_events_t view;
    logic [7:0] flags;
    logic packet_end_read_view;
    logic rx_queue_empty_view;
    logic self_setup_done_view;
    logic osc_ready_view;
    logic nvm_op_done_view;
    logic tx_done_view;
    logic rx_queue_full_view;
    logic packet_arrived_view;
    logic [7:0] view_byte;

    // Next values of the registered outputs
    logic next_ready;
    logic next_err;
    logic [31:0] next_rdata;
    logic [7:0] next_peek;

    ////////////////////////////////////////////////////////////////////
    // Full-width compare; a partial decode would alias other registers
    function automatic logic addr_is(
        input logic [irq_status0_pkg::ADDR_W-1:0] addr,
        input logic [irq_status0_pkg::ADDR_W-1:0] target
    );
        return addr == target;
    endfunction

    // Flag at a named position of the store
    function automatic logic pick(input logic [7:0] store, input int pos);
        return store[pos];
    endfunction

    // Byte in the low lane; upper lanes read as zero
    function automatic logic [31:0] to_word(input logic [7:0] value);
        return irq_status0_pkg::RDATA_ZERO | 32'(value);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus inputs gathered into one request
    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                   paddr: paddr_i, pwdata: pwdata_i};

    // Answer in the cycle after setup: no wait state, pready registered
    assign setup = req.psel && !req.penable;
    assign read_setup = setup && !req.pwrite;

    assign hit_peek = addr_is(req.paddr, irq_status0_pkg::ADDR_STATUS0_PEEK);
    assign hit_clear = addr_is(req.paddr, irq_status0_pkg::ADDR_STATUS0_CLEAR);
    assign mapped = hit_peek || hit_clear;

    // Clear only on companion read
    // Peek reads and all writes leave the store alone
    assign clear_read = read_setup && hit_clear;

    ////////////////////////////////////////////////////////////////////
    // Sources are one-cycle pulses; a held level keeps setting its flag
    // Last packet byte read
    assign events.packet_end_read = packet_end_read_i;

    assign events.rx_queue_empty = rx_queue_empty_i;

    assign events.self_setup_done = self_setup_done_i;

    assign events.osc_ready = osc_ready_i;

    assign events.nvm_op_done = nvm_op_done_i;

    assign events.tx_done = tx_done_i;

    assign events.rx_queue_full = rx_queue_full_i;

    assign events.packet_arrived = packet_arrived_i;

    // Set wins over the clear inside the store
    irq_status0_flags u_flags (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .events_i(events),
        .clear_all_i(clear_read),
        .flags_o(flags)
    );

    ////////////////////////////////////////////////////////////////////
    // Per-bit view of the shared store
    assign packet_end_read_view = pick(flags, irq_status0_pkg::BIT_PACKET_END);

    assign rx_queue_empty_view = pick(flags, irq_status0_pkg::BIT_RX_EMPTY);

    assign self_setup_done_view = pick(flags, irq_status0_pkg::BIT_SELF_SETUP);

    assign osc_ready_view = pick(flags, irq_status0_pkg::BIT_OSC_READY);

    assign nvm_op_done_view = pick(flags, irq_status0_pkg::BIT_NVM_DONE);

    assign tx_done_view = pick(flags, irq_status0_pkg::BIT_TX_DONE);

    assign rx_queue_full_view = pick(flags, irq_status0_pkg::BIT_RX_FULL);

    assign packet_arrived_view = pick(flags, irq_status0_pkg::BIT_PACKET_ARRIVED);

    // Repacked by name so a reordered field cannot move a bit
    assign view = '{
        packet_end_read: packet_end_read_view,
        rx_queue_empty: rx_queue_empty_view,
        self_setup_done: self_setup_done_view,
        osc_ready: osc_ready_view,
        nvm_op_done: nvm_op_done_view,
        tx_done: tx_done_view,
        rx_queue_full: rx_queue_full_view,
        packet_arrived: packet_arrived_view
    };
    assign view_byte = view;

    ////////////////////////////////////////////////////////////////////
    // Writes silently dropped; unmapped errors
    assign next_ready = setup;
    assign next_err = setup && !mapped;

    // Both views sample one store
    // Data taken at the setup edge, before a clear lands
    assign next_rdata = (read_setup && mapped)
                        ? to_word(view_byte) : irq_status0_pkg::RDATA_ZERO;

    // Peek pin trails the store by one cycle
    assign next_peek = view_byte;

    ////////////////////////////////////////////////////////////////////
    // One-cycle answer: high only in the access cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            pready_o <= 1'b0;
        else
            pready_o <= next_ready;
    end

    // Error flag stands beside pready
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            pslverr_o <= 1'b0;
        else
            pslverr_o <= next_err;
    end

    // Read data is zero outside read answers
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            prdata_o <= irq_status0_pkg::RDATA_ZERO;
        else
            prdata_o <= next_rdata;
    end

    // Registered copy of the store for the pin
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            irq_status0_peek_o <= irq_status0_pkg::STATUS0_RESET;
        else
            irq_status0_peek_o <= next_peek;
    end
endmodule

// >>> irq_status0_pkg.sv
// Package for the first-group interrupt status view.
// Assumes an APB master with 32-bit data and one aligned word per register.
package irq_status0_pkg;
    localparam int ADDR_W = 12;
    // Printed offsets are not all multiples of four, so they are indices
    localparam logic [ADDR_W-1:0] IDX_STATUS0_CLEAR = 12'h063;
    localparam logic [ADDR_W-1:0] IDX_STATUS0_PEEK = 12'h076;
    localparam logic [ADDR_W-1:0] ADDR_STATUS0_CLEAR = 12'(IDX_STATUS0_CLEAR * 4);
    localparam logic [ADDR_W-1:0] ADDR_STATUS0_PEEK = 12'(IDX_STATUS0_PEEK * 4);
    localparam logic [7:0] STATUS0_RESET = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;
    localparam int BIT_PACKET_END = 7;
    localparam int BIT_RX_EMPTY = 6;
    localparam int BIT_SELF_SETUP = 5;
    localparam int BIT_OSC_READY = 4;
    localparam int BIT_NVM_DONE = 3;
    localparam int BIT_TX_DONE = 2;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_PACKET_ARRIVED = 0;

    typedef struct packed {
        logic packet_end_read;
        logic rx_queue_empty;
        logic self_setup_done;
        logic osc_ready;
        logic nvm_op_done;
        logic tx_done;
        logic rx_queue_full;
        logic packet_arrived;
    } irq_events_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// >>> tb_top.sv
// Bench: APB reads and writes of the peek view, event pulses.
// Assumes the design package is compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [7:0] irq_status0_peek_o, ev = 8'h00;
    logic pready_o, pslverr_o, er;
    int fail_count = 0, num_checks = 0;
    localparam logic [11:0] PK = irq_status0_pkg::ADDR_STATUS0_PEEK;
    localparam logic [11:0] CL = irq_status0_pkg::ADDR_STATUS0_CLEAR;
    `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
        $display("BAD %s exp %h got %h", n, e, s); end end
    irq_status0_peek_view DUT (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .packet_end_read_i(ev[7]),
        .rx_queue_empty_i(ev[6]),
        .self_setup_done_i(ev[5]),
        .osc_ready_i(ev[4]),
        .nvm_op_done_i(ev[3]),
        .tx_done_i(ev[2]),
        .rx_queue_full_i(ev[1]),
        .packet_arrived_i(ev[0]),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .prdata_o(prdata_o),
        .irq_status0_peek_o(irq_status0_peek_o)
    );
    initial forever #4 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a);
        @(posedge ref_clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        @(posedge ref_clk_i) penable_i <= 1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge ref_clk_i) ev <= v;
        @(posedge ref_clk_i) ev <= 8'h00;
    endtask
    task automatic t_bits;
        logic [7:0] x;
        x = irq_status0_pkg::STATUS0_RESET;
        apb(0, PK);
        `CHK("reset", 32'h0, rd)
        for (int i = 0; i < 8; i++)
        begin
            pulse(8'h01 << i);
            x |= 8'h01 << i;
            apb(0, PK);
            `CHK("peek", {24'h0, x}, rd)
            `CHK("peek_pin", x, irq_status0_peek_o)
        end
        apb(1, PK);
        apb(0, CL);
        `CHK("clear", 32'hFF, rd)
        apb(0, PK);
        `CHK("after", 32'h0, rd)
        `CHK("pin_after", 8'h00, irq_status0_peek_o)
        $display("t_bits done");
    endtask
    task automatic t_misc;
        pulse(8'hA5);
        apb(1, CL);
        `CHK("wr_err", 1'b0, er)
        apb(0, PK);
        `CHK("kept", 32'hA5, rd)
        apb(0, 12'h000);
        `CHK("unmapped", 33'h100000000, {er, rd})
        $display("t_misc done");
    endtask
    task automatic t_reset;
        pulse(8'h3C);
        apb(0, PK);
        `CHK("pre_rst", 32'hBD, rd)
        @(posedge ref_clk_i) rst_n_i <= 0;
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1;
        apb(0, PK);
        `CHK("rst_read", 32'h0, rd)
        `CHK("rst_pin", 8'h00, irq_status0_peek_o)
        $display("t_reset done");
    endtask
    task automatic end_sim;
        $display("checks %0d bad %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1;
        t_bits;
        t_misc;
        t_reset;
        end_sim;
    end
    initial
    begin
        repeat (3000) @(posedge ref_clk_i);
        fail_count++;
        end_sim;
    end
endmodule
